// File: pkg/frec_defs.svh
// Purpose: bit positions and reset values of the rounding/exception block
// Assumes: scalar control/status words 16 bits, simd csr 32 bits
// Notes: flag/mask order from bit 0: inv, den, dz, ovf, unf, prec
`ifndef FREC_DEFS_SVH
`define FREC_DEFS_SVH

// ==========================================================
// exception bit order
`define FREC_EXC_INV 0
`define FREC_EXC_DEN 1
`define FREC_EXC_DZ 2
`define FREC_EXC_OVF 3
`define FREC_EXC_UNF 4
`define FREC_EXC_PREC 5

// ==========================================================
// field positions
`define FREC_SC_FLAG_LO 0
`define FREC_SC_MASK_LO 0
`define FREC_SC_RC_LO 10
`define FREC_SIMD_FLAG_LO 0
`define FREC_SIMD_MASK_LO 7
`define FREC_SIMD_RC_LO 13

// ==========================================================
// reset values: all classes masked, round to nearest
`define FREC_SC_CTRL_RST 16'h003F
`define FREC_SC_STAT_RST 16'h0000
`define FREC_SIMD_CSR_RST 32'h0000_1F80

`endif

// File: pkg/frec_pkg.sv
// Purpose: types of the rounding/exception block
// Assumes: one-hot state codes
// Notes: none
package frec_pkg;

  // ==========================================================
  // rounding mode encoding
  typedef enum logic [1:0] {
    RND_NEAR_EVEN = 2'h0,
    RND_DOWN = 2'h1,
    RND_UP = 2'h2,
    RND_ZERO = 2'h3
  } frec_rnd_t;

  // ==========================================================
  // result the datapath must deliver
  typedef enum logic [1:0] {
    RES_NONE = 2'h0,
    RES_COMPUTED = 2'h1,
    RES_QNAN_INDEF = 2'h2,
    RES_SIGNED_INF = 2'h3
  } frec_res_t;

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_POST = 2'b10
  } frec_state_t;

endpackage : frec_pkg

// File: src/frec_core.sv
// Purpose: rounding selection, sticky exception flags, masked/trap response
// Assumes: datapath raises pre-checks with op_start, post-checks later
// Notes: one operation in flight; op_start ignored while busy
`timescale 1ns/10ps
`include "frec_defs.svh"

// Notes on behaviour
// RULE_01 - rounding mode comes from a two-bit field in a control register
// RULE_02 - scalar control word keeps its rounding field in bits 10 and 11
// RULE_03 - simd control/status register keeps its rounding field in bits 13-14
// RULE_04 - each rounding field steers only its own unit's operations
// RULE_05 - truncating conversions always round toward zero
// RULE_06 - encoding: 00 nearest-even default, 01 down, 10 up, 11 zero
// RULE_07 - six exception classes are detected
// RULE_08 - invalid, divide-by-zero, denormal before arithmetic; others after
// RULE_09 - each class owns flag and mask; flag set before response chosen
// RULE_10 - masked exception gives default result and execution continues
// RULE_11 - unmasked exception raises a trap to the handler
// RULE_12 - flags are sticky until software clears them
// RULE_13 - scalar flags in status bits 0-5, masks in control bits 0-5
// RULE_14 - simd flags in bits 0-5, masks in bits 7-12
// RULE_15 - each flag/mask set serves only its own unit
// RULE_16 - masked responses let one instruction set several flags
// RULE_17 - masked invalid sets flag and writes quiet NaN indefinite
// RULE_18 - unmasked invalid sets flag, traps, leaves operands unmodified
// RULE_19 - masked denormal sets flag and proceeds normally
// RULE_20 - masked divide-by-zero returns infinity signed by operand xor
// RULE_21 - inexact rounded result sets the precision flag
// RULE_22 - bit order: invalid, denormal, dz, overflow, underflow, precision
module frec_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // software access to the scalar words
  input wire logic sc_ctrl_we,
  input wire logic [15:0] sc_ctrl_wdata,
  input wire logic [5:0] sc_flag_clr,
  // software access to the simd control/status register
  input wire logic simd_we,
  input wire logic [31:0] simd_wdata,
  // operation start with pre-computation checks
  input wire logic op_start,
  input wire logic op_simd,
  input wire logic op_trunc,
  input wire logic pre_inv,
  input wire logic pre_den,
  input wire logic pre_dz,
  input wire logic sign_a,
  input wire logic sign_b,
  // post-computation checks
  input wire logic post_valid,
  input wire logic post_ovf,
  input wire logic post_tiny,
  input wire logic post_inexact,
  // register contents
  output logic [15:0] sc_ctrl_word,
  output logic [15:0] sc_status_word,
  output logic [31:0] simd_control_status_reg,
  // response to the datapath
  output logic [1:0] rounding_mode_field,
  output logic busy,
  output logic op_done,
  output logic trap,
  output logic dest_we,
  output logic [1:0] res_kind,
  output logic res_sign
);

  // ==========================================================
  // state
  logic [15:0] sc_ctrl_r;
  logic [15:0] sc_stat_r;
  logic [31:0] simd_csr_r;
  logic [1:0] rnd_r;
  frec_pkg::frec_state_t state_r;
  logic op_simd_r;
  logic done_r;
  logic trap_r;
  logic we_r;
  logic [1:0] res_r;
  logic sign_r;

  logic [5:0] sc_mask;
  logic [5:0] simd_mask;
  logic [5:0] act_mask;
  logic [1:0] sc_rc;
  logic [1:0] simd_rc;
  logic start_ok;
  logic post_ok;
  logic [5:0] pre_set;
  logic [5:0] post_set;
  logic [5:0] exc_set;
  logic pre_trap;
  logic post_trap;
  logic unf_hit;

  assign sc_mask = sc_ctrl_r[`FREC_SC_MASK_LO +: 6]; // RULE_13
  assign simd_mask = simd_csr_r[`FREC_SIMD_MASK_LO +: 6]; // RULE_14
  assign sc_rc = sc_ctrl_r[`FREC_SC_RC_LO +: 2]; // RULE_02
  assign simd_rc = simd_csr_r[`FREC_SIMD_RC_LO +: 2]; // RULE_03
  assign start_ok = op_start && (state_r == frec_pkg::ST_IDLE);
  assign post_ok = post_valid && (state_r == frec_pkg::ST_POST);

  // ==========================================================
  // exception detection
  always_comb begin
    act_mask = op_simd ? simd_mask : sc_mask; // RULE_15
    if (state_r == frec_pkg::ST_POST) begin
      act_mask = op_simd_r ? simd_mask : sc_mask;
    end
    pre_set = 6'h00;
    // pre-computation classes, seen with op_start
    pre_set[`FREC_EXC_INV] = start_ok && pre_inv; // RULE_08
    pre_set[`FREC_EXC_DEN] = start_ok && pre_den; // RULE_08
    pre_set[`FREC_EXC_DZ] = start_ok && pre_dz; // RULE_08
    // masked underflow only reported when also inexact
    unf_hit = post_tiny;
    if (act_mask[`FREC_EXC_UNF]) begin
      unf_hit = post_tiny && post_inexact;
    end
    post_set = 6'h00;
    post_set[`FREC_EXC_OVF] = post_ok && post_ovf; // RULE_08
    post_set[`FREC_EXC_UNF] = post_ok && unf_hit; // RULE_08
    post_set[`FREC_EXC_PREC] = post_ok && post_inexact; // RULE_21
    exc_set = pre_set | post_set; // RULE_07 RULE_22
    pre_trap = |(pre_set & ~act_mask); // RULE_11
    post_trap = |(post_set & ~act_mask); // RULE_11
  end

  // ==========================================================
  // scalar control word
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sc_ctrl_r <= `FREC_SC_CTRL_RST;
    end else if (sc_ctrl_we) begin
      sc_ctrl_r <= 16'h0000;
      sc_ctrl_r[`FREC_SC_MASK_LO +: 6] <=
        sc_ctrl_wdata[`FREC_SC_MASK_LO +: 6];
      sc_ctrl_r[`FREC_SC_RC_LO +: 2] <= sc_ctrl_wdata[`FREC_SC_RC_LO +: 2];
    end
  end

  // ==========================================================
  // scalar status word, sticky flags; a new event beats the clear
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sc_stat_r <= `FREC_SC_STAT_RST;
    end else begin
      sc_stat_r[`FREC_SC_FLAG_LO +: 6] <=
        (sc_stat_r[`FREC_SC_FLAG_LO +: 6] & ~sc_flag_clr) |
        ((start_ok && !op_simd) || (post_ok && !op_simd_r) ?
          exc_set : 6'h00); // RULE_09 RULE_12 RULE_15
    end
  end

  // ==========================================================
  // simd control/status register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      simd_csr_r <= `FREC_SIMD_CSR_RST;
    end else begin
      if (simd_we) begin
        simd_csr_r <= 32'h0000_0000;
        simd_csr_r[`FREC_SIMD_MASK_LO +: 6] <=
          simd_wdata[`FREC_SIMD_MASK_LO +: 6];
        simd_csr_r[`FREC_SIMD_RC_LO +: 2] <=
          simd_wdata[`FREC_SIMD_RC_LO +: 2];
      end
      simd_csr_r[`FREC_SIMD_FLAG_LO +: 6] <=
        (simd_we ? simd_wdata[`FREC_SIMD_FLAG_LO +: 6] :
          simd_csr_r[`FREC_SIMD_FLAG_LO +: 6]) |
        ((start_ok && op_simd) || (post_ok && op_simd_r) ?
          exc_set : 6'h00); // RULE_09 RULE_12 RULE_15
    end
  end

  // ==========================================================
  // rounding mode handed to the datapath, held for the operation
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rnd_r <= frec_pkg::RND_NEAR_EVEN; // RULE_06
    end else if (start_ok) begin
      if (op_trunc) begin
        rnd_r <= frec_pkg::RND_ZERO; // RULE_05
      end else begin
        rnd_r <= op_simd ? simd_rc : sc_rc; // RULE_01 RULE_04
      end
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_r <= frec_pkg::ST_IDLE;
      op_simd_r <= 1'b0;
    end else begin
      case (state_r)
        frec_pkg::ST_IDLE: begin
          if (start_ok) begin
            op_simd_r <= op_simd;
            // masked denormal carries on into the arithmetic
            if (!pre_trap && !pre_inv && !pre_dz) begin
              state_r <= frec_pkg::ST_POST; // RULE_16 RULE_19
            end
          end
        end
        frec_pkg::ST_POST: begin
          if (post_ok) begin
            state_r <= frec_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= frec_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // response: trap or default/computed result
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      done_r <= 1'b0;
      trap_r <= 1'b0;
      we_r <= 1'b0;
      res_r <= frec_pkg::RES_NONE;
      sign_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      trap_r <= 1'b0;
      we_r <= 1'b0;
      if (start_ok && pre_trap) begin
        // any unmasked pre-check lands here, ahead of masked responses
        // operands untouched: no destination write
        done_r <= 1'b1;
        trap_r <= 1'b1; // RULE_11 RULE_18
        res_r <= frec_pkg::RES_NONE;
        sign_r <= 1'b0;
      end else if (start_ok && pre_inv) begin
        done_r <= 1'b1;
        we_r <= 1'b1; // RULE_10
        res_r <= frec_pkg::RES_QNAN_INDEF; // RULE_17
        sign_r <= 1'b0;
      end else if (start_ok && pre_dz) begin
        done_r <= 1'b1;
        we_r <= 1'b1; // RULE_10
        res_r <= frec_pkg::RES_SIGNED_INF; // RULE_20
        sign_r <= sign_a ^ sign_b; // RULE_20
      end else if (post_ok) begin
        done_r <= 1'b1;
        trap_r <= post_trap; // RULE_11
        we_r <= !post_trap; // RULE_10
        res_r <= post_trap ? frec_pkg::RES_NONE : frec_pkg::RES_COMPUTED;
        sign_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // outputs
  assign sc_ctrl_word = sc_ctrl_r;
  assign sc_status_word = sc_stat_r;
  assign simd_control_status_reg = simd_csr_r;
  assign rounding_mode_field = rnd_r;
  // one-hot code: the post bit is the flop itself, no decode
  assign busy = state_r[1];
  assign op_done = done_r;
  assign trap = trap_r;
  assign dest_we = we_r;
  assign res_kind = res_r;
  assign res_sign = sign_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  AST_TRUNC_RZ: assert property ( // RULE_05
    start_ok && op_trunc |=> rounding_mode_field == 2'h3)
    else $error("truncating conversion not rounded toward zero");

  AST_SIMD_RC: assert property ( // RULE_03
    start_ok && op_simd && !op_trunc && !simd_we
      |=> rounding_mode_field == simd_control_status_reg[14:13])
    else $error("simd rounding field not applied");

  AST_SCALAR_RC: assert property ( // RULE_02
    start_ok && !op_simd && !op_trunc && !sc_ctrl_we
      |=> rounding_mode_field == sc_ctrl_word[11:10])
    else $error("scalar rounding field not applied");

  AST_STICKY: assert property ( // RULE_12
    1'b1 |=> (($past(sc_status_word[5:0]) & ~$past(sc_flag_clr) &
      ~sc_status_word[5:0]) == 6'h00))
    else $error("scalar flag dropped without a clear");

  AST_UNMASKED_TRAP: assert property ( // RULE_18
    start_ok && !op_simd && pre_inv && !sc_ctrl_word[0]
      |=> trap && !dest_we && sc_status_word[0])
    else $error("unmasked invalid did not trap cleanly");

  AST_MASKED_INV: assert property ( // RULE_17
    start_ok && op_simd && pre_inv && simd_control_status_reg[12:7] == 6'h3F
      |=> dest_we && res_kind == 2'h2 && !trap
        && simd_control_status_reg[0])
    else $error("masked invalid did not write quiet NaN");

  AST_MASKED_DZ: assert property ( // RULE_20
    start_ok && !op_simd && pre_dz && !pre_inv && sc_ctrl_word[5:0] == 6'h3F
      |=> dest_we && res_kind == 2'h3
        && res_sign == ($past(sign_a) ^ $past(sign_b)) && sc_status_word[2])
    else $error("masked divide-by-zero result wrong");

  AST_DEN_PROCEED: assert property ( // RULE_19
    start_ok && pre_den && !pre_inv && !pre_dz && !pre_trap
      |=> busy && !op_done)
    else $error("masked denormal did not proceed");

  AST_PRECISION: assert property ( // RULE_21
    post_ok && post_inexact && op_simd_r
      |=> simd_control_status_reg[5])
    else $error("inexact result left precision flag clear");

  AST_ISOLATE: assert property ( // RULE_15
    busy && op_simd_r && sc_flag_clr == 6'h00
      |=> sc_status_word == $past(sc_status_word))
    else $error("simd operation touched scalar flags");

  // a new op may start while op_done stands, so a second trap is legal
  AST_POST_TRAP: assert property ( // RULE_11
    post_ok && post_ovf && !act_mask[3]
      |=> (trap && !dest_we) ##1 (!trap || $past(start_ok)))
    else $error("unmasked overflow did not trap once");

  COV_TRAP: cover property (start_ok && pre_trap ##1 trap);
  COV_MULTI: cover property (
    start_ok && pre_den ##[1:20] post_ok && post_tiny && post_inexact);
  COV_TRUNC: cover property (start_ok && op_trunc && op_simd);
  COV_POST_TRAP: cover property (post_ok && post_trap ##1 trap);
  COV_DZ_INF: cover property (
    start_ok && pre_dz && !pre_trap ##1 res_kind == 2'h3);

endmodule : frec_core

// File: bench/frec_dpath_model.sv
// Purpose: arithmetic datapath stand-in that answers post checks
// Assumes: one operation in flight, busy marks the wait for results
// Notes: wait_cycles lets the bench answer promptly or slowly
`timescale 1ns/10ps

module frec_dpath_model (
  // clock and handshake
  input wire logic core_clk,
  input wire logic busy,
  input wire logic [1:0] wait_cycles,
  // outcome of the arithmetic
  input wire logic ovf_in,
  input wire logic tiny_in,
  input wire logic inexact_in,
  // post checks toward the core
  output logic post_valid,
  output logic post_ovf,
  output logic post_tiny,
  output logic post_inexact
);
  // ==========================================================
  // post checks
  logic [1:0] cnt_r;

  initial begin
    post_valid = 1'b0;
    {post_ovf, post_tiny, post_inexact} = 3'b000;
    cnt_r = 2'b00;
  end

  // results only after the arithmetic has run
  // plain always: the initial block above seeds these same variables
  always @(posedge core_clk) begin
    if (busy && !post_valid && cnt_r == wait_cycles) begin
      post_valid <= 1'b1;
      {post_ovf, post_tiny, post_inexact} <= {ovf_in, tiny_in, inexact_in};
    end else begin
      post_valid <= 1'b0;
      // outside a valid cycle the lines carry no meaning, so keep them moving
      {post_ovf, post_tiny, post_inexact} <=
        ~{post_ovf, post_tiny, post_inexact};
    end
    cnt_r <= (busy && !post_valid) ? cnt_r + 2'b01 : 2'b00;
  end
endmodule : frec_dpath_model

// File: bench/testbench.sv
// Purpose: self-checking bench of the rounding/exception core
// Assumes: results are compared in order of issue
// Notes: datapath side is the model, software side is driven here
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
  logic core_clk, resetn, sc_ctrl_we, simd_we, op_start, op_simd, op_trunc;
  logic pre_inv, pre_den, pre_dz, sign_a, sign_b;
  logic post_valid, post_ovf, post_tiny, post_inexact;
  logic p_ovf, p_tiny, p_inx, busy, op_done, trap, dest_we, res_sign;
  logic [15:0] sc_ctrl_wdata, sc_ctrl_word, sc_status_word;
  logic [31:0] simd_wdata, simd_control_status_reg, seed;
  logic [5:0] sc_flag_clr;
  logic [1:0] rounding_mode_field, res_kind, p_wait;
  logic [13:0] exp_q[$];
  logic [13:0] e;
  int mismatches, checks, cycles;

  frec_core dut (.core_clk(core_clk), .resetn(resetn),
    .sc_ctrl_we(sc_ctrl_we), .sc_ctrl_wdata(sc_ctrl_wdata),
    .sc_flag_clr(sc_flag_clr), .simd_we(simd_we), .simd_wdata(simd_wdata),
    .op_start(op_start), .op_simd(op_simd), .op_trunc(op_trunc),
    .pre_inv(pre_inv), .pre_den(pre_den), .pre_dz(pre_dz),
    .sign_a(sign_a), .sign_b(sign_b), .post_valid(post_valid),
    .post_ovf(post_ovf), .post_tiny(post_tiny), .post_inexact(post_inexact),
    .sc_ctrl_word(sc_ctrl_word), .sc_status_word(sc_status_word),
    .simd_control_status_reg(simd_control_status_reg),
    .rounding_mode_field(rounding_mode_field), .busy(busy),
    .op_done(op_done), .trap(trap), .dest_we(dest_we),
    .res_kind(res_kind), .res_sign(res_sign));

  frec_dpath_model partner (.core_clk(core_clk), .busy(busy),
    .wait_cycles(p_wait), .ovf_in(p_ovf), .tiny_in(p_tiny),
    .inexact_in(p_inx), .post_valid(post_valid), .post_ovf(post_ovf),
    .post_tiny(post_tiny), .post_inexact(post_inexact));

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // mask and value of {sign, trap, write, kind, rounding}
  function automatic logic [13:0] ex(input logic tr, we, input logic [1:0] kd,
      input logic rc, input logic [1:0] rn, input logic cs, sg);
    return {cs, 2'b11, {2{~tr}}, {2{rc}}, sg, tr, we, kd, rn};
  endfunction : ex

  task automatic wrap_up;
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic wr_sc(input logic [15:0] d);
    @(posedge core_clk);
    #1 sc_ctrl_we = 1'b1;
    sc_ctrl_wdata = d;
    @(posedge core_clk);
    #1 sc_ctrl_we = 1'b0;
  endtask : wr_sc

  task automatic wr_simd(input logic [31:0] d);
    @(posedge core_clk);
    #1 simd_we = 1'b1;
    simd_wdata = d;
    @(posedge core_clk);
    #1 simd_we = 1'b0;
  endtask : wr_simd

  // pre checks ride with the start pulse, post checks come from the partner
  task automatic run_op(input logic s, t, i, d, z, o, ty, nx,
      input logic [13:0] x);
    int k;
    exp_q.push_back(x);
    // draw from the current seed so callers can predict the signs
    {p_wait, sign_a, sign_b} = seed[3:0];
    seed = xs(seed);
    {p_ovf, p_tiny, p_inx} = {o, ty, nx};
    @(posedge core_clk);
    #1 {op_start, op_simd, op_trunc, pre_inv, pre_den, pre_dz} =
      {1'b1, s, t, i, d, z};
    @(posedge core_clk);
    #1 {op_start, pre_inv, pre_den, pre_dz} = 4'b0000;
    `CHK(busy, !(i || z))
    for (k = 0; k < 40 && op_done !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
  endtask : run_op

  // ==========================================================
  // clock, timeout and result watcher
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      wrap_up();
    end else if (op_done === 1'b1) begin
      e = exp_q.pop_front();
      `CHK({res_sign, trap, dest_we, res_kind, rounding_mode_field} & e[13:7], e[6:0] & e[13:7])
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {resetn, sc_ctrl_we, simd_we, op_start, op_simd, op_trunc} = 6'h00;
    {pre_inv, pre_den, pre_dz, sign_a, sign_b} = 5'h00;
    {p_ovf, p_tiny, p_inx, p_wait} = 5'h00;
    sc_ctrl_wdata = 16'h0000;
    simd_wdata = 32'h0000_0000;
    sc_flag_clr = 6'h00;
    seed = 32'h0000_DADA;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    repeat (2) @(posedge core_clk);
    #1 resetn = 1'b1;
    `CHK({sc_ctrl_word, sc_status_word, rounding_mode_field}, 34'h0_00FC_0000)
    `CHK(simd_control_status_reg, 32'h0000_1F80)
    wr_sc(16'hFFFF);
    `CHK(sc_ctrl_word, 16'h0C3F)
    wr_simd(32'hFFFF_FFFF);
    `CHK(simd_control_status_reg, 32'h0000_7FBF)
    wr_simd(32'h0000_1F80);
    // every mode on both units, other unit set apart, truncation on and off
    for (int u = 0; u < 2; u++) begin
      for (int m = 0; m < 4; m++) begin
        for (int t = 0; t < 2; t++) begin
          wr_sc({4'h0, m[1:0], 10'h03F});
          wr_simd({17'h0, ~m[1:0], 13'h1F80});
          run_op(u[0], t[0], 0, 0, 0, 0, 0, 0, ex(0, 1, 2'h1, 1,
            t ? 2'h3 : (u ? ~m[1:0] : m[1:0]), 0, 0));
        end
      end
    end
    `CHK({sc_status_word, simd_control_status_reg}, 48'h0000_0000_1F80)
    wr_sc(16'h003F);
    run_op(0, 0, 0, 0, 1, 0, 0, 0, ex(0, 1, 2'h3, 0, 0, 1, seed[1] ^ seed[0]));
    `CHK(sc_status_word, 16'h0004)
    run_op(1, 0, 1, 0, 0, 0, 0, 0, ex(0, 1, 2'h2, 0, 0, 0, 0));
    `CHK(simd_control_status_reg, 32'h0000_1F81)
    run_op(1, 0, 0, 1, 0, 0, 1, 1, ex(0, 1, 2'h1, 0, 0, 0, 0));
    `CHK(simd_control_status_reg, 32'h0000_1FB3)
    `CHK(sc_status_word, 16'h0004)
    @(posedge core_clk);
    #1 sc_flag_clr = 6'h04;
    @(posedge core_clk);
    #1 sc_flag_clr = 6'h00;
    `CHK(sc_status_word, 16'h0000)
    wr_sc(16'h003E);
    run_op(0, 0, 1, 0, 0, 0, 0, 0, ex(1, 0, 2'h0, 0, 0, 0, 0));
    `CHK(sc_status_word, 16'h0001)
    wr_simd(32'h0000_1B80);
    run_op(1, 0, 0, 0, 0, 1, 0, 0, ex(1, 0, 2'h0, 0, 0, 0, 0));
    `CHK(simd_control_status_reg, 32'h0000_1B88)
    wr_sc(16'h003F);
    run_op(0, 0, 0, 0, 0, 1, 0, 0, ex(0, 1, 2'h1, 0, 0, 0, 0));
    `CHK(sc_status_word, 16'h0009)
    repeat (3) @(posedge core_clk);
    `CHK(exp_q.size(), 0)
    wrap_up();
  end
endmodule : testbench
